// File: rtl/ecu_pkg.sv
// Constants for the capture/compare unit: register map, fields, mode codes.
// Assumes one 200 MHz clock and a plain strobe register port.
// ----------------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------------
package ecu_pkg;
  localparam logic [1:0] ADDR_CONTROL  = 2'h0;
  localparam logic [1:0] ADDR_VAL_LOW  = 2'h1;
  localparam logic [1:0] ADDR_VAL_HIGH = 2'h2;
  localparam logic [1:0] ADDR_STATUS   = 2'h3;
  localparam int CFG_MSB  = 7;
  localparam int CFG_LSB  = 6;
  localparam int DUTY_MSB = 5;
  localparam int DUTY_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam int STAT_FLAG = 0;
  localparam int STAT_OUT  = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4    = 4'h6;
  localparam logic [3:0] MODE_CAP_16   = 4'h7;
  localparam logic [3:0] MODE_SET      = 4'h8;
  localparam logic [3:0] MODE_CLEAR    = 4'h9;
  localparam logic [3:0] MODE_SOFT     = 4'hA;
  localparam logic [3:0] MODE_TRIGGER  = 4'hB;
  localparam logic [1:0] CFG_SINGLE    = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD  = 2'h1;
  localparam logic [1:0] CFG_HALF      = 2'h2;
  localparam logic [1:0] CFG_FULL_REV  = 2'h3;
  localparam logic [3:0] PRESCALE_4_MAX  = 4'h3;
  localparam logic [3:0] PRESCALE_16_MAX = 4'hF;
endpackage

// File: rtl/ecu_top.sv
// Capture/compare unit with PWM output steering and polarity.
// Assumes timers and the PWM modulator live outside on the same clock; the pin is async.
//
// Our own choices: the placing of the registers and strobed register access.
module ecu_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic [1:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        capture_compare_pin_in,
  input  wire logic [15:0] first_timer_pair_in,
  input  wire logic [15:0] second_timer_pair_in,
  input  wire logic [1:0]  timer_route_select_in,
  input  wire logic        timer_sw_write_in,
  input  wire logic        unit_irq_flag_clear_in,
  input  wire logic        pwm_mod_in,
  input  wire logic        pwm_mod_comp_in,
  output logic             unit_irq_flag_out,
  output logic             trigger_timer_clear_out,
  output logic             trigger_convert_out,
  output logic             compare_out,
  output logic             pwm_out_a_out,
  output logic             pwm_out_b_out,
  output logic             pwm_out_c_out,
  output logic             pwm_out_d_out,
  output logic             pwm_own_a_out,
  output logic             pwm_own_b_out,
  output logic             pwm_own_c_out,
  output logic             pwm_own_d_out,
  output logic             pwm_mode_out,
  output logic [9:0]       pwm_duty_out
);
  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  logic [7:0]  unit_control_reg;
  logic [15:0] value;
  logic        wr_ctrl;
  logic        wr_low;
  logic        wr_high;
  logic        wr_stat;
  logic [3:0]  mode_select;
  logic [1:0]  output_config;
  logic        cap_mode;
  logic        cmp_mode;
  logic        pwm_mode;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == ecu_pkg::ADDR_CONTROL);
  assign wr_low  = reg_wr_in && (reg_addr_in == ecu_pkg::ADDR_VAL_LOW);
  assign wr_high = reg_wr_in && (reg_addr_in == ecu_pkg::ADDR_VAL_HIGH);
  assign wr_stat = reg_wr_in && (reg_addr_in == ecu_pkg::ADDR_STATUS);

  assign mode_select   = unit_control_reg[ecu_pkg::MODE_MSB:0];
  assign output_config = unit_control_reg[ecu_pkg::CFG_MSB:ecu_pkg::CFG_LSB];
  assign cap_mode = (mode_select[3:2] == 2'b01);
  assign pwm_mode = (mode_select[3:2] == 2'b11);
  assign cmp_mode = (mode_select == ecu_pkg::MODE_TOGGLE) ||
                    (mode_select[3:2] == 2'b10);

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unit_control_reg <= ecu_pkg::CONTROL_RESET;
    end else if (wr_ctrl) begin
      unit_control_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ecu_pkg::ADDR_CONTROL:  reg_rdata_out <= unit_control_reg;
        ecu_pkg::ADDR_VAL_LOW:  reg_rdata_out <= value[7:0];
        ecu_pkg::ADDR_VAL_HIGH: reg_rdata_out <= value[15:8];
        ecu_pkg::ADDR_STATUS:   reg_rdata_out <= {6'h00, compare_out, unit_irq_flag_out};
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ---------------------------------------------------------------------------
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_last_reg;
  logic rise;
  logic fall;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= capture_compare_pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end

  assign rise = pin_sync_reg && !pin_last_reg;
  assign fall = !pin_sync_reg && pin_last_reg;

  // ---------------------------------------------------------------------------
  // Capture
  // ---------------------------------------------------------------------------
  logic [3:0]  prescale_reg;
  logic [3:0]  prescale_max;
  logic        cap_event;
  logic [15:0] timer_sel;

  assign timer_sel = timer_route_select_in[1] ? second_timer_pair_in : first_timer_pair_in;

  assign prescale_max = (mode_select == ecu_pkg::MODE_CAP_16) ? ecu_pkg::PRESCALE_16_MAX
                                                              : ecu_pkg::PRESCALE_4_MAX;

  always_comb begin
    cap_event = 1'b0;
    unique case (mode_select)
      ecu_pkg::MODE_CAP_FALL: cap_event = fall;
      ecu_pkg::MODE_CAP_RISE: cap_event = rise;
      ecu_pkg::MODE_CAP_4,
      ecu_pkg::MODE_CAP_16:   cap_event = rise && (prescale_reg >= prescale_max);
      default:                cap_event = 1'b0;
    endcase
  end

  // kept across prescale change
  // Counter is shared; a 16-count left over can fire early at the 4 setting
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prescale_reg <= 4'h0;
    end else if (!cap_mode) begin
      prescale_reg <= 4'h0;
    end else if (rise && (mode_select == ecu_pkg::MODE_CAP_4 ||
                          mode_select == ecu_pkg::MODE_CAP_16)) begin
      prescale_reg <= (prescale_reg >= prescale_max) ? 4'h0 : prescale_reg + 4'h1;
    end
  end

  ecu_value_reg u_value (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .cap_load_in (cap_event),
    .cap_data_in (timer_sel),
    .wr_low_in   (wr_low),
    .wr_high_in  (wr_high),
    .wr_data_in  (reg_wdata_in),
    .value_out   (value)
  );

  // ---------------------------------------------------------------------------
  // Compare
  // ---------------------------------------------------------------------------
  logic match;
  logic irq_set;

  assign match   = cmp_mode && (value == timer_sel);
  assign irq_set = cap_event || match;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unit_irq_flag_out <= 1'b0;
    end else if (irq_set) begin
      unit_irq_flag_out <= 1'b1;
    end else if (unit_irq_flag_clear_in || (wr_stat && !reg_wdata_in[ecu_pkg::STAT_FLAG])) begin
      unit_irq_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      compare_out <= 1'b0;
    end else if (mode_select == ecu_pkg::MODE_OFF) begin
      compare_out <= 1'b0;
    end else if (match) begin
      unique case (mode_select)
        ecu_pkg::MODE_TOGGLE: compare_out <= !compare_out;
        ecu_pkg::MODE_SET:    compare_out <= 1'b1;
        ecu_pkg::MODE_CLEAR:  compare_out <= 1'b0;
        default:              compare_out <= compare_out;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trigger_timer_clear_out <= 1'b0;
      trigger_convert_out     <= 1'b0;
    end else begin
      trigger_timer_clear_out <= match && (mode_select == ecu_pkg::MODE_TRIGGER) && !timer_sw_write_in;
      trigger_convert_out     <= match && (mode_select == ecu_pkg::MODE_TRIGGER);
    end
  end

  // ---------------------------------------------------------------------------
  // PWM steering and polarity
  // ---------------------------------------------------------------------------
  logic pol_ac;
  logic pol_bd;
  logic a_raw;
  logic b_raw;
  logic c_raw;
  logic d_raw;
  logic pwm_own_a;
  logic pwm_own_b;
  logic pwm_own_c;
  logic pwm_own_d;
  logic pwm_out_a_reg;
  logic pwm_out_b_reg;
  logic pwm_out_c_reg;
  logic pwm_out_d_reg;

  assign pol_ac = mode_select[1];
  assign pol_bd = mode_select[0];

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_duty_out <= 10'h000;
      pwm_mode_out <= 1'b0;
    end else begin
      pwm_mode_out <= pwm_mode;
      pwm_duty_out <= pwm_mode ? {value[7:0], unit_control_reg[ecu_pkg::DUTY_MSB:ecu_pkg::DUTY_LSB]}
                               : 10'h000;
    end
  end

  always_comb begin
    a_raw     = 1'b0;
    b_raw     = 1'b0;
    c_raw     = 1'b0;
    d_raw     = 1'b0;
    pwm_own_a = 1'b1;
    pwm_own_b = 1'b0;
    pwm_own_c = 1'b0;
    pwm_own_d = 1'b0;
    if (pwm_mode) begin
      unique case (output_config)
        ecu_pkg::CFG_SINGLE: begin
          a_raw = pwm_mod_in;
        end
        ecu_pkg::CFG_FULL_FWD: begin
          a_raw     = 1'b1;
          d_raw     = pwm_mod_in;
          pwm_own_b = 1'b1;
          pwm_own_c = 1'b1;
          pwm_own_d = 1'b1;
        end
        ecu_pkg::CFG_HALF: begin
          a_raw     = pwm_mod_in;
          b_raw     = pwm_mod_comp_in;
          pwm_own_b = 1'b1;
        end
        ecu_pkg::CFG_FULL_REV: begin
          c_raw     = 1'b1;
          b_raw     = pwm_mod_in;
          pwm_own_b = 1'b1;
          pwm_own_c = 1'b1;
          pwm_own_d = 1'b1;
        end
      endcase
    end
  end

  // Pins registered to keep outputs glitch free
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_out_a_reg <= 1'b0;
      pwm_out_b_reg <= 1'b0;
      pwm_out_c_reg <= 1'b0;
      pwm_out_d_reg <= 1'b0;
    end else if (pwm_mode) begin
      pwm_out_a_reg <= a_raw ^ pol_ac;
      pwm_out_b_reg <= pwm_own_b & (b_raw ^ pol_bd);
      pwm_out_c_reg <= pwm_own_c & (c_raw ^ pol_ac);
      pwm_out_d_reg <= pwm_own_d & (d_raw ^ pol_bd);
    end else begin
      pwm_out_a_reg <= compare_out;
      pwm_out_b_reg <= 1'b0;
      pwm_out_c_reg <= 1'b0;
      pwm_out_d_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------------
  assign pwm_out_a_out = pwm_out_a_reg;
  assign pwm_out_b_out = pwm_out_b_reg;
  assign pwm_out_c_out = pwm_out_c_reg;
  assign pwm_out_d_out = pwm_out_d_reg;
  assign pwm_own_a_out = pwm_own_a;
  assign pwm_own_b_out = pwm_own_b;
  assign pwm_own_c_out = pwm_own_c;
  assign pwm_own_d_out = pwm_own_d;
endmodule

// File: rtl/ecu_value_reg.sv
// Holds the 16-bit capture/compare value as two byte lanes.
// Assumes capture load and software byte writes come from the same clock.
module ecu_value_reg (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        cap_load_in,
  input  wire logic [15:0] cap_data_in,
  input  wire logic        wr_low_in,
  input  wire logic        wr_high_in,
  input  wire logic [7:0]  wr_data_in,
  output logic      [15:0] value_out
);
  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // Capture wins over a same-cycle software write: hardware event not lost
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      value_out <= 16'h0000;
    end else if (cap_load_in) begin
      value_out <= cap_data_in;
    end else begin
      if (wr_low_in) begin
        value_out[7:0] <= wr_data_in;
      end
      if (wr_high_in) begin
        value_out[15:8] <= wr_data_in;
      end
    end
  end
endmodule

// File: tb/ecu_timer_model.sv
// Behavioural timer pair on the far side of compare and capture.
// Assumes loads and the unit's trigger share the one clock.
module ecu_timer_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        run_in,
  input  wire logic        load_in,
  input  wire logic [15:0] load_val_in,
  input  wire logic        clear_in,
  output logic      [15:0] count_out
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) count_out <= 16'h0000;
    else if (load_in) count_out <= load_val_in;
    else if (clear_in) count_out <= 16'h0000;
    else if (run_in) count_out <= count_out + 16'h0001;
  end
endmodule

// File: tb/ecu_top_sva.sv
// Checker on the unit's top ports: flag, triggers, read port, PWM duty.
// Assumes bind into ecu_top; one clock, async active-low reset.
module ecu_top_sva (
  input wire logic       mclk_in,
  input wire logic       rst_b_in,
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       timer_sw_write_in,
  input wire logic       unit_irq_flag_clear_in,
  input wire logic       unit_irq_flag_out,
  input wire logic       trigger_timer_clear_out,
  input wire logic       trigger_convert_out,
  input wire logic       compare_out,
  input wire logic       pwm_mode_out,
  input wire logic [9:0] pwm_duty_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------
  // Properties
  // ----------
  logic [7:0] ctrl_reg;
  logic       clr_wr;
  logic       trig_mode;
  // Rebuilt from bus writes, so a stale design register cannot hide
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) ctrl_reg <= 8'h00;
    else if (reg_wr_in && reg_addr_in == 2'h0) ctrl_reg <= reg_wdata_in;
  end
  assign clr_wr    = reg_wr_in && reg_addr_in == 2'h3 && !reg_wdata_in[0];
  assign trig_mode = ctrl_reg[3:0] == 4'hB;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_flag_sticky: assert property (
    $fell(unit_irq_flag_out) |-> $past(unit_irq_flag_clear_in) || $past(clr_wr) || ctrl_reg[3:0] == 4'h0
  ) else $error("flag fell with no clear");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_trig_pair: assert property (trigger_timer_clear_out |-> trigger_convert_out)
    else $error("timer clear without convert");
  a_trig_flag: assert property (trigger_convert_out |-> unit_irq_flag_out && $past(trig_mode))
    else $error("trigger without flag or mode");
  a_sw_wins: assert property ($past(timer_sw_write_in) |-> !trigger_timer_clear_out)
    else $error("clear beat a timer write");
  a_duty_off: assert property (!pwm_mode_out |-> pwm_duty_out == 10'h000)
    else $error("duty outside PWM");
  a_duty_low: assert property (pwm_mode_out && $stable(ctrl_reg) |-> pwm_duty_out[1:0] == ctrl_reg[5:4])
    else $error("duty low bits wrong");
  a_mode_follow: assert property ($stable(ctrl_reg) |-> pwm_mode_out == (ctrl_reg[3:2] == 2'b11))
    else $error("PWM mode flag wrong");
  a_latch_clear: assert property (
    reg_wr_in && reg_addr_in == 2'h0 && reg_wdata_in[3:0] == 4'h0 |-> ##[1:2] !compare_out
  ) else $error("compare latch not cleared");
  c_trigger: cover property (trigger_convert_out);
  c_flag_clear: cover property ($fell(unit_irq_flag_out));
  c_pwm: cover property (pwm_mode_out && pwm_duty_out[1:0] == 2'b11);
endmodule
bind ecu_top ecu_top_sva i_ecu_top_sva (
  .mclk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .timer_sw_write_in, .unit_irq_flag_clear_in, .unit_irq_flag_out, .trigger_timer_clear_out,
  .trigger_convert_out, .compare_out, .pwm_mode_out, .pwm_duty_out
);

// File: tb/ecu_top_tb.sv
// Self-checking bench for the capture/compare unit and its timer model.
// Assumes the checker is bound to ecu_top; one 200 MHz clock.
module ecu_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in, rst_b_in, reg_wr_in, reg_rd_in, capture_compare_pin_in, timer_sw_write_in, t_run;
  logic        unit_irq_flag_clear_in, pwm_mod_in, pwm_mod_comp_in, unit_irq_flag_out, compare_out;
  logic        trigger_timer_clear_out, trigger_convert_out, pwm_mode_out, pwm_out_a_out, pwm_out_b_out;
  logic        pwm_out_c_out, pwm_out_d_out, pwm_own_a_out, pwm_own_b_out, pwm_own_c_out, pwm_own_d_out;
  logic [1:0]  reg_addr_in, timer_route_select_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out;
  logic [9:0]  pwm_duty_out;
  logic [15:0] first_timer_pair_in, second_timer_pair_in, t_val;
  int          mismatches, checks_done, cycles;
  ecu_top i_ecu_top (
    .mclk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .capture_compare_pin_in, .first_timer_pair_in, .second_timer_pair_in, .timer_route_select_in,
    .timer_sw_write_in, .unit_irq_flag_clear_in, .pwm_mod_in, .pwm_mod_comp_in, .unit_irq_flag_out,
    .trigger_timer_clear_out, .trigger_convert_out, .compare_out, .pwm_out_a_out, .pwm_out_b_out,
    .pwm_out_c_out, .pwm_out_d_out, .pwm_own_a_out, .pwm_own_b_out, .pwm_own_c_out, .pwm_own_d_out,
    .pwm_mode_out, .pwm_duty_out
  );
  ecu_timer_model i_timer (
    .mclk_in, .rst_b_in, .run_in(t_run), .load_in(timer_sw_write_in), .load_val_in(t_val),
    .clear_in(trigger_timer_clear_out), .count_out(first_timer_pair_in)
  );
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Whole run needs about 900 cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("Error at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end
  // ----------
  // Bus tasks
  // ----------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask
  task automatic ld(input logic [15:0] v);
    @(posedge mclk_in);
    t_val <= v;
    timer_sw_write_in <= 1'b1;
    @(posedge mclk_in);
    timer_sw_write_in <= 1'b0;
  endtask
  // Pin levels held well over the two-flop sync
  task automatic pulse();
    @(posedge mclk_in);
    capture_compare_pin_in <= 1'b1;
    cyc(4);
    capture_compare_pin_in <= 1'b0;
    cyc(5);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    rc(2'h0, 8'h00);
    chk({compare_out, pwm_own_a_out, pwm_own_b_out}, 3'b010);
    wr(2'h1, 8'h5A);
    wr(2'h2, 8'hC3);
    wr(2'h0, 8'h33);
    rc(2'h1, 8'h5A);
    rc(2'h2, 8'hC3);
    rc(2'h0, 8'h33);
    $display("test regs done");
  endtask
  task automatic t_capture();
    int n [4] = '{1, 1, 4, 16};
    for (int i = 0; i < 4; i++) begin
      wr(2'h0, 8'h00);
      ld(16'h1200 + 16'(i));
      wr(2'h0, 8'h04 + 8'(i));
      wr(2'h3, 8'h00);
      repeat (n[i] - 1) pulse();
      #1 chk(unit_irq_flag_out, 1'b0);
      pulse();
      #1 chk(unit_irq_flag_out, 1'b1);
      rc(2'h1, 8'(i));
      rc(2'h2, 8'h12);
    end
    $display("test capture done");
  endtask
  task automatic t_switch();
    wr(2'h0, 8'h00);
    wr(2'h0, 8'h06);
    repeat (3) pulse();
    wr(2'h0, 8'h07);
    wr(2'h3, 8'h00);
    repeat (12) pulse();
    #1 chk(unit_irq_flag_out, 1'b0);
    pulse();
    #1 chk(unit_irq_flag_out, 1'b1);
    $display("test switch done");
  endtask
  task automatic t_overwrite();
    wr(2'h0, 8'h05);
    ld(16'h1111);
    pulse();
    @(posedge mclk_in);
    unit_irq_flag_clear_in <= 1'b1;
    timer_route_select_in <= 2'b10;
    second_timer_pair_in <= 16'hBEEF;
    @(posedge mclk_in);
    unit_irq_flag_clear_in <= 1'b0;
    #1 chk(unit_irq_flag_out, 1'b0);
    pulse();
    timer_route_select_in <= 2'b00;
    rc(2'h1, 8'hEF);
    rc(2'h2, 8'hBE);
    $display("test overwrite done");
  endtask
  task automatic t_compare();
    logic [3:0] m [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
    logic       e [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h40);
    wr(2'h2, 8'h00);
    for (int i = 0; i < 5; i++) begin
      ld(16'h0030);
      wr(2'h0, {4'h0, m[i]});
      wr(2'h3, 8'h00);
      t_run <= 1'b1;
      cyc(30);
      t_run <= 1'b0;
      #1 chk(compare_out, e[i]);
      chk({pwm_out_a_out, pwm_own_c_out, pwm_own_d_out}, {e[i], 2'b00});
      chk(unit_irq_flag_out, 1'b1);
      if (m[i] == 4'hB) chk(first_timer_pair_in < 16'h0030, 1'b1);
    end
    // Timer write held across a trigger match must keep its value
    @(posedge mclk_in);
    t_val <= 16'h0040;
    timer_sw_write_in <= 1'b1;
    cyc(2);
    timer_sw_write_in <= 1'b0;
    #1 chk(trigger_timer_clear_out, 1'b0);
    chk(first_timer_pair_in, 16'h0040);
    wr(2'h0, 8'h00);
    cyc(2);
    #1 chk(compare_out, 1'b0);
    $display("test compare done");
  endtask
  task automatic t_pwm();
    logic [3:0] own_t [4] = '{4'b1000, 4'b1111, 4'b1100, 4'b1111};
    logic [3:0] hi_t [4] = '{4'b1000, 4'b1001, 4'b1000, 4'b0110};
    logic [3:0] lo_t [4] = '{4'b0000, 4'b1000, 4'b0100, 4'b0010};
    logic [4:0] k;
    logic [3:0] pin;
    wr(2'h1, 8'hA5);
    for (int j = 0; j < 32; j++) begin
      k = 5'(j);
      @(posedge mclk_in);
      pwm_mod_in <= k[4];
      pwm_mod_comp_in <= !k[4];
      wr(2'h0, {k[3:2], k[3:2], 2'b11, k[1:0]});
      cyc(3);
      #1 pin = (k[4] ? hi_t[k[3:2]] : lo_t[k[3:2]]) ^ {k[1], k[0], k[1], k[0]};
      chk({pwm_own_a_out, pwm_own_b_out, pwm_own_c_out, pwm_own_d_out}, own_t[k[3:2]]);
      chk({pwm_out_a_out, pwm_out_b_out, pwm_out_c_out, pwm_out_d_out} & own_t[k[3:2]],
          pin & own_t[k[3:2]]);
      chk(pwm_duty_out, {8'hA5, k[3:2]});
    end
    wr(2'h0, 8'h00);
    $display("test pwm done");
  endtask
  initial begin
    {rst_b_in, reg_wr_in, reg_rd_in, capture_compare_pin_in, timer_sw_write_in, t_run} = '0;
    {unit_irq_flag_clear_in, pwm_mod_in, pwm_mod_comp_in, reg_addr_in, timer_route_select_in} = '0;
    {reg_wdata_in, second_timer_pair_in, t_val} = '0;
    cyc(8);
    rst_b_in <= 1'b1;
    t_regs();
    t_capture();
    t_switch();
    t_overwrite();
    t_compare();
    t_pwm();
    tally_and_finish();
  end
endmodule
